/* File: memory_map_control_regs.sv */
// Memory map control: page, direct page, mode and map control regs
`timescale 1ns/1ps
module memory_map_control_regs
  import mmc_pkg::*;
#(
  parameter int PAGE_W = PAGE_BITS
)
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       mode_pin_n,
  input  wire logic       device_secured,
  input  bus_req_t        bus_req,
  output logic [7:0]      bus_rdata,
  output logic            bus_rvalid,
  input  wire logic       call_wr,
  input  wire logic [7:0] call_wdata,
  output logic [7:0]      call_rdata,
  input  xlat_req_t       cpu_req,
  output xlat_rsp_t       cpu_rsp,
  input  xlat_req_t       dbg_req,
  output xlat_rsp_t       dbg_rsp,
  output logic            mode_select_bit,
  output logic            op_mode_normal,
  output logic            mode_locked,
  output logic [7:0]      direct_page_bits,
  output logic            direct_locked,
  output logic            info_row_visible
);

  // ==========================================================
  // Elaboration check
  if (PAGE_W != PAGE_BITS)
  begin : g_bad_width
    $error("page index width must be four bits");
  end

  // ==========================================================
  // Declarations
  top_state_t  state;
  top_state_t  next_state;
  logic        hit_page;
  logic        hit_direct;
  logic        hit_mode;
  logic        hit_map;
  logic        hit_any;
  logic        wr_page;
  logic        wr_direct;
  logic        wr_map;
  logic        wr_mode;
  logic        mode_bit;
  logic        mode_eff;
  logic        lock_flag;
  logic        direct_ok;
  logic [7:0]  page_full;
  logic [7:0]  read_mux;
  xlat_rsp_t   cpu_xlat;
  xlat_rsp_t   dbg_xlat;

  // ==========================================================
  // Address decode
  assign hit_page   = bus_req.addr == PAGE_INDEX_ADDR;
  assign hit_direct = bus_req.addr == DIRECT_PAGE_ADDR;
  assign hit_mode   = bus_req.addr == MODE_SEL_ADDR;
  assign hit_map    = bus_req.addr == MAP_CTL_ADDR;
  assign hit_any    = hit_page || hit_direct || hit_mode || hit_map;

  assign wr_page    = bus_req.wr && hit_page;
  assign wr_direct  = bus_req.wr && hit_direct;
  assign wr_map     = bus_req.wr && hit_map;
  assign wr_mode    = bus_req.wr && hit_mode;

  // ==========================================================
  // Mode control
  mode_guard u_mode_guard
  (
    .clk_sys         (clk_sys),
    .rst_n           (rst_n),
    .mode_pin_n      (mode_pin_n),
    .device_secured  (device_secured),
    .mode_wr         (wr_mode),
    .mode_wdata      (bus_req.wdata[MODE_BIT_POS]),
    .mode_select_bit (mode_bit),
    .mode_now        (mode_eff),
    .mode_locked     (lock_flag)
  );

  // ==========================================================
  // Direct page write permission
  assign direct_ok = (mode_eff == MODE_SPECIAL) ||
                     !state.direct_written;

  // ==========================================================
  // Read data selection
  assign page_full = {PAGE_UPPER_FILL, state.page_index};

  always_comb
  begin
    read_mux = 8'h00;
    if (hit_page)
      read_mux = page_full;
    else if (hit_direct)
      read_mux = state.direct_bits;
    else if (hit_mode)
      read_mux[MODE_BIT_POS] = mode_bit;
    else if (hit_map)
      read_mux[INFO_VIS_POS] = state.info_vis;
  end

  // ==========================================================
  // Address translation for both masters
  page_translator u_cpu_xlat
  (
    .req         (cpu_req),
    .page_index  (state.page_index),
    .direct_bits (state.direct_bits),
    .info_vis    (state.info_vis),
    .rsp         (cpu_xlat)
  );

  page_translator u_dbg_xlat
  (
    .req         (dbg_req),
    .page_index  (state.page_index),
    .direct_bits (state.direct_bits),
    .info_vis    (state.info_vis),
    .rsp         (dbg_xlat)
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    next_state = state;
    if (!rst_n)
    begin
      next_state.page_index     = PAGE_INDEX_RESET[3:0];
      next_state.direct_bits    = DIRECT_RESET;
      next_state.direct_written = 1'b0;
      next_state.info_vis       = INFO_VIS_RESET;
      next_state.rdata          = 8'h00;
      next_state.rvalid         = 1'b0;
      next_state.cpu_rsp        = '0;
      next_state.dbg_rsp        = '0;
    end
    else
    begin
      // Call path takes priority over an ordinary write
      if (call_wr)
        next_state.page_index = call_wdata[3:0];
      else if (wr_page)
        next_state.page_index = bus_req.wdata[3:0];

      if (wr_direct && direct_ok)
      begin
        next_state.direct_bits    = bus_req.wdata;
        next_state.direct_written = 1'b1;
      end

      if (wr_map)
        next_state.info_vis = bus_req.wdata[INFO_VIS_POS];

      next_state.rvalid = bus_req.rd && hit_any;
      if (bus_req.rd && hit_any)
        next_state.rdata = read_mux;

      next_state.cpu_rsp = cpu_xlat;
      next_state.dbg_rsp = dbg_xlat;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    state <= next_state;
  end

  // ==========================================================
  // Outputs
  assign bus_rdata        = state.rdata;
  assign bus_rvalid       = state.rvalid;
  assign call_rdata       = page_full;
  assign cpu_rsp          = state.cpu_rsp;
  assign dbg_rsp          = state.dbg_rsp;
  assign mode_select_bit  = mode_bit;
  assign op_mode_normal   = mode_eff;
  assign mode_locked      = lock_flag;
  assign direct_page_bits = state.direct_bits;
  assign direct_locked    = !direct_ok;
  assign info_row_visible = state.info_vis;

endmodule

/* File: mmc_pkg.sv */
// Constants and carrier types for the memory map control block
package mmc_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [15:0] PAGE_INDEX_ADDR  = 16'h0030;
  localparam logic [15:0] DIRECT_PAGE_ADDR = 16'h0031;
  localparam logic [15:0] MODE_SEL_ADDR    = 16'h0032;
  localparam logic [15:0] MAP_CTL_ADDR     = 16'h0033;

  // ==========================================================
  // Reset values and field positions
  localparam logic [7:0]  PAGE_INDEX_RESET = 8'hFE;
  localparam logic [3:0]  PAGE_UPPER_FILL  = 4'hF;
  localparam logic [7:0]  DIRECT_RESET     = 8'h00;
  localparam logic        INFO_VIS_RESET   = 1'b0;
  localparam int          MODE_BIT_POS     = 7;
  localparam int          INFO_VIS_POS     = 0;
  localparam logic        MODE_SPECIAL     = 1'b0;
  localparam logic        MODE_NORMAL      = 1'b1;

  // ==========================================================
  // Address map
  localparam int          LOCAL_W          = 16;
  localparam int          GLOBAL_W         = 18;
  localparam int          PAGE_BITS        = 4;
  localparam logic [1:0]  WINDOW_QUARTER   = 2'b10;
  localparam logic [7:0]  FIXED_PAGE_LOW   = 8'hFC;
  localparam logic [7:0]  FIXED_PAGE_MID   = 8'hFD;
  localparam logic [7:0]  FIXED_PAGE_HIGH  = 8'hFF;
  localparam logic [15:0] RESOURCE_TOP     = 16'h0800;
  localparam logic [17:0] INFO_ROW_LOW     = 18'h00400;
  localparam logic [17:0] INFO_ROW_HIGH    = 18'h0047F;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } bus_req_t;

  typedef struct packed {
    logic        valid;
    logic        direct;
    logic [15:0] addr;
  } xlat_req_t;

  typedef struct packed {
    logic        valid;
    logic [17:0] gaddr;
    logic [7:0]  page;
    logic        in_window;
    logic        info_row_hit;
    logic        info_row_unmapped;
  } xlat_rsp_t;

  typedef struct packed {
    logic mode_bit;
    logic locked;
  } mode_state_t;

  typedef struct packed {
    logic [3:0] page_index;
    logic [7:0] direct_bits;
    logic       direct_written;
    logic       info_vis;
    logic [7:0] rdata;
    logic       rvalid;
    xlat_rsp_t  cpu_rsp;
    xlat_rsp_t  dbg_rsp;
  } top_state_t;

endpackage

/* File: mode_guard.sv */
// Operating mode select bit with strap capture and write guard
`timescale 1ns/1ps
module mode_guard
  import mmc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic mode_pin_n,
  input  wire logic device_secured,
  input  wire logic mode_wr,
  input  wire logic mode_wdata,
  output logic      mode_select_bit,
  output logic      mode_now,
  output logic      mode_locked
);

  mode_state_t state;
  mode_state_t next_state;

  // ==========================================================
  // Next state
  always_comb
  begin
    next_state = state;
    if (!rst_n)
    begin
      next_state.mode_bit = mode_pin_n;
      next_state.locked   = 1'b0;
    end
    else if (mode_wr && !(state.locked &&
             state.mode_bit == MODE_NORMAL))
    begin
      if (mode_wdata != state.mode_bit)
      begin
        if (state.mode_bit == MODE_SPECIAL &&
            mode_wdata == MODE_NORMAL && !device_secured)
          next_state.mode_bit = mode_wdata;
        else
          next_state.locked = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    state <= next_state;
  end

  // ==========================================================
  // Outputs
  assign mode_select_bit = state.mode_bit;
  assign mode_now        = rst_n ? state.mode_bit : mode_pin_n;
  assign mode_locked     = state.locked;

endmodule

/* File: page_translator.sv */
// Local to global address translation for one bus master
`timescale 1ns/1ps
module page_translator
  import mmc_pkg::*;
(
  input  xlat_req_t         req,
  input  wire logic [3:0]   page_index,
  input  wire logic [7:0]   direct_bits,
  input  wire logic         info_vis,
  output xlat_rsp_t         rsp
);

  logic [15:0] local_addr;
  logic [7:0]  page;
  logic [17:0] gaddr;
  logic        in_info;

  always_comb
  begin
    // Direct mode supplies the upper byte
    local_addr = req.direct ? {direct_bits, req.addr[7:0]}
                            : req.addr;
    case (local_addr[15:14])
      2'b00:   page = FIXED_PAGE_LOW;
      2'b01:   page = FIXED_PAGE_MID;
      2'b10:   page = {PAGE_UPPER_FILL, page_index};
      2'b11:   page = FIXED_PAGE_HIGH;
      default: page = FIXED_PAGE_HIGH;
    endcase
    // Register, info row and RAM space sits at the global bottom
    if (local_addr < RESOURCE_TOP)
      gaddr = {4'h0, local_addr[13:0]};
    else
      gaddr = {page[3:0], local_addr[13:0]};
    in_info = gaddr >= INFO_ROW_LOW && gaddr <= INFO_ROW_HIGH;
    rsp.valid             = req.valid;
    rsp.gaddr             = gaddr;
    rsp.page              = page;
    rsp.in_window         = local_addr[15:14] == WINDOW_QUARTER;
    rsp.info_row_hit      = in_info && info_vis;
    rsp.info_row_unmapped = in_info && !info_vis;
  end

endmodule

/* File: mmc_chk.sv */
// Port assertions for the memory map control block
`timescale 1ns/1ps
module mmc_chk
  import mmc_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       mode_pin_n,
  input wire logic       device_secured,
  input bus_req_t        bus_req,
  input wire logic       bus_rvalid,
  input wire logic       call_wr,
  input wire logic [7:0] call_wdata,
  input wire logic [7:0] call_rdata,
  input xlat_req_t       cpu_req,
  input xlat_rsp_t       cpu_rsp,
  input xlat_req_t       dbg_req,
  input xlat_rsp_t       dbg_rsp,
  input wire logic       mode_select_bit,
  input wire logic       op_mode_normal,
  input wire logic [7:0] direct_page_bits,
  input wire logic       direct_locked,
  input wire logic       info_row_visible
);
  // ==========================================================
  // Sequences and properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence rd_dec;
    bus_req.rd && bus_req.addr[15:2] == 14'h000C;
  endsequence
  sequence win_req;
    cpu_req.valid && !cpu_req.direct && cpu_req.addr[15:14] == 2'h2;
  endsequence
  sequence dir_wr;
    bus_req.wr && bus_req.addr == DIRECT_PAGE_ADDR;
  endsequence
  chk_read_answer: assert property (rd_dec |=> bus_rvalid)
    else $error("decoded read gave no answer");
  chk_call_write: assert property (call_wr |=>
    call_rdata == ($past(call_wdata) | 8'hF0))
    else $error("call path write not seen");
  chk_window_map: assert property (win_req |=>
    cpu_rsp.in_window && cpu_rsp.page == $past(call_rdata))
    else $error("window page mismatch");
  chk_fixed_top: assert property (dbg_req.valid && !dbg_req.direct
    && dbg_req.addr[15:14] == 2'h3 |=> dbg_rsp.page == FIXED_PAGE_HIGH)
    else $error("top quarter page mismatch");
  chk_strap_latch: assert property ($rose(rst_n) |->
    mode_select_bit == $past(mode_pin_n))
    else $error("strap not latched");
  chk_secured_hold: assert property (device_secured |=>
    $stable(mode_select_bit))
    else $error("mode changed while secured");
  chk_direct_once: assert property (op_mode_normal && direct_locked
    ##0 dir_wr |=> $stable(direct_page_bits))
    else $error("direct page rewritten");
  chk_info_write: assert property (bus_req.wr &&
    bus_req.addr == MAP_CTL_ADDR |=>
    info_row_visible == $past(bus_req.wdata[INFO_VIS_POS]))
    else $error("info row bit not written");
endmodule

/* File: cpu_master.sv */
// Model of the CPU and debug masters
`timescale 1ns/1ps
module cpu_master
  import mmc_pkg::*;
(
  input  wire logic       clk_sys,
  output bus_req_t        bus_req,
  input  wire logic [7:0] bus_rdata,
  input  wire logic       bus_rvalid,
  output logic            call_wr,
  output logic [7:0]      call_wdata,
  input  wire logic [7:0] call_rdata,
  output xlat_req_t       cpu_req,
  output xlat_req_t       dbg_req,
  input  xlat_rsp_t       cpu_rsp,
  input  xlat_rsp_t       dbg_rsp
);
  initial
  begin
    bus_req = '0;
    call_wr = 1'h0;
    call_wdata = 8'h00;
    cpu_req = '0;
    dbg_req = '0;
  end
  // ==========================================================
  // Transfers; released data shows the inverse of the last value
  task automatic wr(input logic [15:0] a, input logic [7:0] dt);
    @(posedge clk_sys);
    bus_req <= '{1'h0, 1'h1, a, dt};
    @(posedge clk_sys);
    bus_req <= '{1'h0, 1'h0, ~a, ~dt};
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] dt,
                    output logic vl);
    @(posedge clk_sys);
    bus_req <= '{1'h1, 1'h0, a, 8'h00};
    @(posedge clk_sys);
    bus_req <= '{1'h0, 1'h0, ~a, 8'hFF};
    #1;
    vl = bus_rvalid;
    dt = bus_rdata;
  endtask
  task automatic call(input logic [7:0] dt, output logic [7:0] q);
    @(posedge clk_sys);
    call_wr <= 1'h1;
    call_wdata <= dt;
    @(posedge clk_sys);
    call_wr <= 1'h0;
    call_wdata <= ~dt;
    #1;
    q = call_rdata;
  endtask
  task automatic xl(input logic dbg, input logic dir,
                    input logic [15:0] a, output xlat_rsp_t r);
    @(posedge clk_sys);
    if (dbg)
      dbg_req <= '{1'h1, dir, a};
    else
      cpu_req <= '{1'h1, dir, a};
    @(posedge clk_sys);
    cpu_req <= '{1'h0, 1'h0, ~a};
    dbg_req <= '{1'h0, 1'h0, ~a};
    #1;
    r = dbg ? dbg_rsp : cpu_rsp;
  endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the memory map control block
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp=%0h got=%0h", n, e, a); end end
module tb;
  import mmc_pkg::*;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic mode_pin_n = 1'h0;
  logic device_secured = 1'h0;
  int n_fail = 0;
  int checked = 0;
  bus_req_t bus_req;
  xlat_req_t cpu_req, dbg_req;
  xlat_rsp_t cpu_rsp, dbg_rsp, r;
  logic [7:0] bus_rdata, call_wdata, call_rdata, direct_page_bits, d;
  logic bus_rvalid, call_wr, mode_select_bit, op_mode_normal, v;
  logic mode_locked, direct_locked, info_row_visible;
  always #5 clk_sys = ~clk_sys;
  memory_map_control_regs u_dut(.clk_sys, .rst_n, .mode_pin_n,
    .device_secured, .bus_req, .bus_rdata, .bus_rvalid, .call_wr,
    .call_wdata, .call_rdata, .cpu_req, .cpu_rsp, .dbg_req, .dbg_rsp,
    .mode_select_bit, .op_mode_normal, .mode_locked,
    .direct_page_bits, .direct_locked, .info_row_visible);
  cpu_master u_m(.clk_sys, .bus_req, .bus_rdata, .bus_rvalid, .call_wr,
    .call_wdata, .call_rdata, .cpu_req, .dbg_req, .cpu_rsp, .dbg_rsp);
  // ==========================================================
  // Helpers
  task automatic conclude();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic do_reset(input logic pin);
    @(posedge clk_sys);
    rst_n <= 1'h0;
    mode_pin_n <= pin;
    repeat (5) @(posedge clk_sys);
    `CHK("reset mode", pin, op_mode_normal)
    rst_n <= 1'h1;
  endtask
  task automatic rchk(input string n, input logic [15:0] a,
                      input logic [7:0] e);
    u_m.rd(a, d, v);
    `CHK(n, 1'h1, v)
    `CHK(n, e, d)
  endtask
  task automatic xchk(input logic dbg, input logic dir, input logic [15:0] a,
                      input logic [17:0] ge, input logic [7:0] pe);
    u_m.xl(dbg, dir, a, r);
    `CHK("valid", 1'h1, r.valid)
    `CHK("gaddr", ge, r.gaddr)
    `CHK("page", pe, r.page)
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_page();
    rchk("page rst", PAGE_INDEX_ADDR, 8'hFE);
    rchk("mode rst", MODE_SEL_ADDR, 8'h00);
    rchk("map rst", MAP_CTL_ADDR, 8'h00);
    u_m.rd(16'h0034, d, v);
    `CHK("unmapped", 1'h0, v)
    u_m.wr(PAGE_INDEX_ADDR, 8'h05);
    rchk("page rd", PAGE_INDEX_ADDR, 8'hF5);
    xchk(1'h0, 1'h0, 16'h8123, 18'h14123, 8'hF5);
    xchk(1'h1, 1'h0, 16'hBFFF, 18'h17FFF, 8'hF5);
    xchk(1'h1, 1'h0, 16'h1000, 18'h31000, 8'hFC);
    xchk(1'h0, 1'h0, 16'h4100, 18'h34100, 8'hFD);
    xchk(1'h1, 1'h0, 16'hC010, 18'h3C010, 8'hFF);
    u_m.call(8'hA7, d);
    `CHK("call rd", 8'hF7, d)
    xchk(1'h0, 1'h0, 16'h8000, 18'h1C000, 8'hF7);
    $display("test page done");
  endtask
  task automatic t_direct();
    u_m.wr(DIRECT_PAGE_ADDR, 8'h12);
    u_m.wr(DIRECT_PAGE_ADDR, 8'h80);
    rchk("direct", DIRECT_PAGE_ADDR, 8'h80);
    `CHK("dir open", 1'h0, direct_locked)
    `CHK("dp bits", 8'h80, direct_page_bits)
    xchk(1'h0, 1'h1, 16'h0045, 18'h1C045, 8'hF7);
    $display("test direct done");
  endtask
  task automatic t_mode();
    @(posedge clk_sys);
    device_secured <= 1'h1;
    u_m.wr(MODE_SEL_ADDR, 8'h80);
    rchk("secured", MODE_SEL_ADDR, 8'h00);
    @(posedge clk_sys);
    device_secured <= 1'h0;
    u_m.wr(MODE_SEL_ADDR, 8'h80);
    rchk("to normal", MODE_SEL_ADDR, 8'h80);
    `CHK("op mode", 1'h1, op_mode_normal)
    u_m.wr(MODE_SEL_ADDR, 8'h00);
    rchk("refused", MODE_SEL_ADDR, 8'h80);
    `CHK("locked", 1'h1, mode_locked)
    u_m.wr(DIRECT_PAGE_ADDR, 8'h33);
    rchk("dir once", DIRECT_PAGE_ADDR, 8'h80);
    `CHK("dir lock", 1'h1, direct_locked)
    $display("test mode done");
  endtask
  task automatic t_info();
    u_m.wr(MAP_CTL_ADDR, 8'hFF);
    rchk("map rd", MAP_CTL_ADDR, 8'h01);
    u_m.xl(1'h0, 1'h0, 16'h0420, r);
    `CHK("row hit", 1'h1, r.info_row_hit)
    u_m.wr(MAP_CTL_ADDR, 8'h00);
    u_m.xl(1'h1, 1'h0, 16'h047F, r);
    `CHK("row off", 1'h1, r.info_row_unmapped)
    do_reset(1'h1);
    rchk("strap", MODE_SEL_ADDR, 8'h80);
    rchk("page rst2", PAGE_INDEX_ADDR, 8'hFE);
    `CHK("unlocked", 1'h0, mode_locked)
    `CHK("dir reopen", 1'h0, direct_locked)
    u_m.wr(DIRECT_PAGE_ADDR, 8'h44);
    u_m.wr(DIRECT_PAGE_ADDR, 8'h55);
    rchk("dir first", DIRECT_PAGE_ADDR, 8'h44);
    u_m.wr(MODE_SEL_ADDR, 8'h00);
    rchk("no return", MODE_SEL_ADDR, 8'h80);
    `CHK("relocked", 1'h1, mode_locked)
    $display("test info done");
  endtask
  initial
  begin
    #100000;
    n_fail++;
    conclude();
  end
  initial
  begin
    do_reset(1'h0);
    t_page();
    t_direct();
    t_mode();
    t_info();
    conclude();
  end
endmodule
bind memory_map_control_regs mmc_chk u_chk(.clk_sys, .rst_n, .mode_pin_n,
  .device_secured, .bus_req, .bus_rvalid, .call_wr, .call_wdata,
  .call_rdata, .cpu_req, .cpu_rsp, .dbg_req, .dbg_rsp, .mode_select_bit,
  .op_mode_normal, .direct_page_bits, .direct_locked, .info_row_visible);
